// ===== shared/jtd_defs.vh
// Purpose: Constants for the test access port block
// Assumes: Included by the core file by bare name
// Notes:   Instruction codes, chain lengths, state codes, capture and identity values
`ifndef JTD_DEFS_VH
`define JTD_DEFS_VH

`define JTD_IR_W        8
`define JTD_OP_MEMCMD   8'h10
`define JTD_OP_MEMRD    8'h11
`define JTD_OP_MEMWR    8'h12
`define JTD_OP_PCCTX    8'h13
`define JTD_OP_DBGCTL   8'h14
`define JTD_OP_IDCODE   8'hFE
`define JTD_OP_EXTEST   8'hF8
`define JTD_OP_SAMPLE   8'hFA
`define JTD_OP_BYPASS   8'hFF
`define JTD_OP_RUNBIST  8'h07
`define JTD_OP_SCANTST  8'h0F

`define JTD_LEN_MEMCMD  6'd37
`define JTD_LEN_MEMRD   6'd32
`define JTD_LEN_MEMWR   6'd32
`define JTD_LEN_PCCTX   6'd37
`define JTD_LEN_DBGCTL  6'd15
`define JTD_LEN_ID      6'd32
`define JTD_LEN_BIST    6'd16
`define JTD_LEN_BSC     6'd8
`define JTD_LEN_BYPASS  6'd1

`define JTD_IR_CAPTURE  8'h01
// Identity value is arbitrary
`define JTD_ID_VALUE    32'h00000001

`define JTD_ST_TLR      4'h0
`define JTD_ST_RTI      4'h1
`define JTD_ST_SELDR    4'h2
`define JTD_ST_CAPDR    4'h3
`define JTD_ST_SHDR     4'h4
`define JTD_ST_EX1DR    4'h5
`define JTD_ST_PAUSEDR  4'h6
`define JTD_ST_EX2DR    4'h7
`define JTD_ST_UPDDR    4'h8
`define JTD_ST_SELIR    4'h9
`define JTD_ST_CAPIR    4'hA
`define JTD_ST_SHIR     4'hB
`define JTD_ST_EX1IR    4'hC
`define JTD_ST_PAUSEIR  4'hD
`define JTD_ST_EX2IR    4'hE
`define JTD_ST_UPDIR    4'hF

`endif

// ===== core/jtd_tap.v
// Purpose: Test access port with instruction register and debug scan chains
// Assumes: REF_CLK far faster than TCK; TCK, TMS, TDI sampled by three flops
// Notes:   Private chains expose parallel capture and update ports only
`timescale 1ns/1ps
`include "jtd_defs.vh"

module jtd_tap (
	input  wire         REF_CLK,
	input  wire         NRST,
	input  wire         TCK,
	input  wire         TMS,
	input  wire         TDI,
	output reg          TDO_OUT,
	output reg          TDO_OE,
	input  wire [36:0]  MEM_CMD_CAP,
	input  wire [31:0]  MEM_RD_VALUE,
	input  wire [31:0]  MEM_WR_CAP,
	input  wire [36:0]  PC_CTX_VALUE,
	input  wire [14:0]  DBG_CTRL_CAP,
	input  wire [15:0]  BIST_RESULT,
	input  wire [7:0]   PIN_IN,
	output reg  [36:0]  MEM_CMD_OUT,
	output reg          MEM_CMD_STB,
	output reg  [31:0]  MEM_WR_OUT,
	output reg          MEM_WR_STB,
	output reg  [14:0]  DBG_CTRL_OUT,
	output reg          DBG_CTRL_STB,
	output reg  [7:0]   BSC_OUT,
	output reg          EXTEST_MODE,
	output reg          BIST_START,
	output reg          SCAN_TEST_MODE,
	output reg  [7:0]   IR_ACTIVE
);

	// Pin samplers: index 0 is TCK, 1 is TMS, 2 is TDI
	wire [2:0]  pin_raw;
	wire [2:0]  pin_agree;
	wire [2:0]  pin_new;
	wire [2:0]  pin_lvl;
	wire        tck_lvl;
	wire        tms_lvl;
	wire        tdi_lvl;
	wire        tck_rise;
	wire        tck_fall;
	wire        shifting;

	// Controller and shift path
	reg  [3:0]  state_ff;
	reg  [3:0]  nxt_state;
	reg  [7:0]  ir_sh_ff;
	reg  [7:0]  nxt_ir_sh;
	reg  [7:0]  nxt_ir_active;
	reg  [36:0] dr_sh_ff;
	reg  [36:0] nxt_dr_sh;
	reg  [36:0] dr_cap;
	reg  [5:0]  dr_len;
	reg         nxt_tdo;
	reg         bist_go;

	// Decoded controller states
	wire        st_tlr;
	wire        st_capdr;
	wire        st_shdr;
	wire        st_upddr;
	wire        st_capir;
	wire        st_shir;
	wire        st_updir;

	// Decoded instruction in force
	wire        sel_memcmd;
	wire        sel_memrd;
	wire        sel_memwr;
	wire        sel_pcctx;
	wire        sel_dbgctl;
	wire        sel_idcode;
	wire        sel_extest;
	wire        sel_sample;
	wire        sel_runbist;
	wire        sel_scantst;
	wire        sel_bsc;

	assign pin_raw = {TDI, TMS, TCK};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
			reg [2:0] sync_ff;
			reg       lvl_ff;
			// TCK idles low, TMS and TDI idle high: no false edge after reset
			always @(posedge REF_CLK) begin
				if (!NRST) begin
					sync_ff <= (gi == 0) ? 3'h0 : 3'h7;
					lvl_ff  <= (gi != 0);
				end else begin
					sync_ff <= {sync_ff[1:0], pin_raw[gi]};
					if (sync_ff[1] == sync_ff[2])
						lvl_ff <= sync_ff[2];
				end
			end
			assign pin_agree[gi] = (sync_ff[1] == sync_ff[2]);
			assign pin_new[gi]   = sync_ff[2];
			assign pin_lvl[gi]   = lvl_ff;
		end
	endgenerate

	assign tck_lvl  = pin_lvl[0];
	assign tms_lvl  = pin_lvl[1];
	assign tdi_lvl  = pin_lvl[2];

	// Edge seen when the agreed level differs from the held one
	assign tck_rise = pin_agree[0] && pin_new[0] && !tck_lvl;
	assign tck_fall = pin_agree[0] && !pin_new[0] && tck_lvl;

	assign st_tlr   = (state_ff == `JTD_ST_TLR);
	assign st_capdr = (state_ff == `JTD_ST_CAPDR);
	assign st_shdr  = (state_ff == `JTD_ST_SHDR);
	assign st_upddr = (state_ff == `JTD_ST_UPDDR);
	assign st_capir = (state_ff == `JTD_ST_CAPIR);
	assign st_shir  = (state_ff == `JTD_ST_SHIR);
	assign st_updir = (state_ff == `JTD_ST_UPDIR);
	assign shifting = st_shdr || st_shir;

	assign sel_memcmd  = (IR_ACTIVE == `JTD_OP_MEMCMD);
	assign sel_memrd   = (IR_ACTIVE == `JTD_OP_MEMRD);
	assign sel_memwr   = (IR_ACTIVE == `JTD_OP_MEMWR);
	assign sel_pcctx   = (IR_ACTIVE == `JTD_OP_PCCTX);
	assign sel_dbgctl  = (IR_ACTIVE == `JTD_OP_DBGCTL);
	assign sel_idcode  = (IR_ACTIVE == `JTD_OP_IDCODE);
	assign sel_extest  = (IR_ACTIVE == `JTD_OP_EXTEST);
	assign sel_sample  = (IR_ACTIVE == `JTD_OP_SAMPLE);
	assign sel_runbist = (IR_ACTIVE == `JTD_OP_RUNBIST);
	assign sel_scantst = (IR_ACTIVE == `JTD_OP_SCANTST);
	// One code serves sample and preload
	assign sel_bsc     = sel_extest || sel_sample;

	always @* begin
		case (state_ff)
		`JTD_ST_TLR:     nxt_state = tms_lvl ? `JTD_ST_TLR   : `JTD_ST_RTI;
		`JTD_ST_RTI:     nxt_state = tms_lvl ? `JTD_ST_SELDR : `JTD_ST_RTI;
		`JTD_ST_SELDR:   nxt_state = tms_lvl ? `JTD_ST_SELIR : `JTD_ST_CAPDR;
		`JTD_ST_CAPDR:   nxt_state = tms_lvl ? `JTD_ST_EX1DR : `JTD_ST_SHDR;
		`JTD_ST_SHDR:    nxt_state = tms_lvl ? `JTD_ST_EX1DR : `JTD_ST_SHDR;
		`JTD_ST_EX1DR:   nxt_state = tms_lvl ? `JTD_ST_UPDDR : `JTD_ST_PAUSEDR;
		`JTD_ST_PAUSEDR: nxt_state = tms_lvl ? `JTD_ST_EX2DR : `JTD_ST_PAUSEDR;
		`JTD_ST_EX2DR:   nxt_state = tms_lvl ? `JTD_ST_UPDDR : `JTD_ST_SHDR;
		`JTD_ST_UPDDR:   nxt_state = tms_lvl ? `JTD_ST_SELDR : `JTD_ST_RTI;
		`JTD_ST_SELIR:   nxt_state = tms_lvl ? `JTD_ST_TLR   : `JTD_ST_CAPIR;
		`JTD_ST_CAPIR:   nxt_state = tms_lvl ? `JTD_ST_EX1IR : `JTD_ST_SHIR;
		`JTD_ST_SHIR:    nxt_state = tms_lvl ? `JTD_ST_EX1IR : `JTD_ST_SHIR;
		`JTD_ST_EX1IR:   nxt_state = tms_lvl ? `JTD_ST_UPDIR : `JTD_ST_PAUSEIR;
		`JTD_ST_PAUSEIR: nxt_state = tms_lvl ? `JTD_ST_EX2IR : `JTD_ST_PAUSEIR;
		`JTD_ST_EX2IR:   nxt_state = tms_lvl ? `JTD_ST_UPDIR : `JTD_ST_SHIR;
		`JTD_ST_UPDIR:   nxt_state = tms_lvl ? `JTD_ST_SELDR : `JTD_ST_RTI;
		default:         nxt_state = `JTD_ST_TLR;
		endcase
	end

	// Selected chain length; undefined codes fall to bypass
	always @* begin
		case (IR_ACTIVE)
		`JTD_OP_MEMCMD:  dr_len = `JTD_LEN_MEMCMD;
		`JTD_OP_MEMRD:   dr_len = `JTD_LEN_MEMRD;
		`JTD_OP_MEMWR:   dr_len = `JTD_LEN_MEMWR;
		`JTD_OP_PCCTX:   dr_len = `JTD_LEN_PCCTX;
		`JTD_OP_DBGCTL:  dr_len = `JTD_LEN_DBGCTL;
		`JTD_OP_IDCODE:  dr_len = `JTD_LEN_ID;
		`JTD_OP_EXTEST:  dr_len = `JTD_LEN_BSC;
		`JTD_OP_SAMPLE:  dr_len = `JTD_LEN_BSC;
		`JTD_OP_RUNBIST: dr_len = `JTD_LEN_BIST;
		default:         dr_len = `JTD_LEN_BYPASS;
		endcase
	end

	// Parallel value loaded at Capture-DR, zero above the chain
	always @* begin
		dr_cap = 37'h0;
		if (sel_memcmd)
			dr_cap = MEM_CMD_CAP;
		else if (sel_memrd)
			dr_cap[31:0] = MEM_RD_VALUE;
		else if (sel_memwr)
			dr_cap[31:0] = MEM_WR_CAP;
		else if (sel_pcctx)
			dr_cap = PC_CTX_VALUE;
		else if (sel_dbgctl)
			dr_cap[14:0] = DBG_CTRL_CAP;
		else if (sel_idcode)
			dr_cap[31:0] = `JTD_ID_VALUE;
		else if (sel_bsc)
			dr_cap[7:0] = PIN_IN;
		else if (sel_runbist)
			dr_cap[15:0] = BIST_RESULT;
		else
			dr_cap = 37'h0;
	end

	// Shift right; TDI enters at the top of the selected chain
	always @* begin
		nxt_dr_sh = dr_sh_ff;
		if (st_capdr)
			nxt_dr_sh = dr_cap;
		else if (st_shdr) begin
			nxt_dr_sh = dr_sh_ff >> 1;
			nxt_dr_sh[dr_len - 6'd1] = tdi_lvl;
		end
	end

	always @* begin
		nxt_ir_sh = ir_sh_ff;
		if (st_capir)
			nxt_ir_sh = `JTD_IR_CAPTURE;
		else if (st_shir)
			nxt_ir_sh = {tdi_lvl, ir_sh_ff[7:1]};
	end

	// Entering or staying in Test-Logic-Reset restores the identity code
	always @* begin
		nxt_ir_active = IR_ACTIVE;
		bist_go = 1'b0;
		if (st_tlr || (nxt_state == `JTD_ST_TLR))
			nxt_ir_active = `JTD_OP_IDCODE;
		else if (st_updir) begin
			nxt_ir_active = ir_sh_ff;
			bist_go = (ir_sh_ff == `JTD_OP_RUNBIST);
		end
	end

	always @* begin
		if (st_shir)
			nxt_tdo = ir_sh_ff[0];
		else
			nxt_tdo = dr_sh_ff[0];
	end

	// Controller and shift registers advance only on a detected TCK rise
	always @(posedge REF_CLK) begin
		if (!NRST) begin
			state_ff  <= `JTD_ST_TLR;
			ir_sh_ff  <= 8'h00;
			dr_sh_ff  <= 37'h0;
			IR_ACTIVE <= `JTD_OP_IDCODE;
		end else if (tck_rise) begin
			state_ff  <= nxt_state;
			ir_sh_ff  <= nxt_ir_sh;
			dr_sh_ff  <= nxt_dr_sh;
			IR_ACTIVE <= nxt_ir_active;
		end
	end

	// TDO and its enable move only on a detected TCK fall
	always @(posedge REF_CLK) begin
		if (!NRST) begin
			TDO_OUT <= 1'b0;
			TDO_OE  <= 1'b0;
		end else if (tck_fall) begin
			TDO_OUT <= nxt_tdo;
			TDO_OE  <= shifting;
		end
	end

	// Mode levels trail the instruction in force by one cycle
	always @(posedge REF_CLK) begin
		if (!NRST) begin
			EXTEST_MODE    <= 1'b0;
			SCAN_TEST_MODE <= 1'b0;
			BIST_START     <= 1'b0;
		end else begin
			EXTEST_MODE    <= sel_extest;
			SCAN_TEST_MODE <= sel_scantst;
			BIST_START     <= tck_rise && bist_go;
		end
	end

	// Update-DR loads the parallel side; strobes last one cycle
	always @(posedge REF_CLK) begin
		if (!NRST) begin
			MEM_CMD_OUT  <= 37'h0;
			MEM_CMD_STB  <= 1'b0;
			MEM_WR_OUT   <= 32'h0;
			MEM_WR_STB   <= 1'b0;
			DBG_CTRL_OUT <= 15'h0;
			DBG_CTRL_STB <= 1'b0;
			BSC_OUT      <= 8'h00;
		end else begin
			MEM_CMD_STB  <= 1'b0;
			MEM_WR_STB   <= 1'b0;
			DBG_CTRL_STB <= 1'b0;
			if (tck_rise && st_upddr) begin
				if (sel_memcmd) begin
					MEM_CMD_OUT <= dr_sh_ff;
					MEM_CMD_STB <= 1'b1;
				end
				if (sel_memwr) begin
					MEM_WR_OUT <= dr_sh_ff[31:0];
					MEM_WR_STB <= 1'b1;
				end
				if (sel_dbgctl) begin
					DBG_CTRL_OUT <= dr_sh_ff[14:0];
					DBG_CTRL_STB <= 1'b1;
				end
				// Boundary update register drives the pins in external test
				if (sel_bsc)
					BSC_OUT <= dr_sh_ff[7:0];
			end
		end
	end

endmodule

// ===== dv/jtd_probe.sv
// Purpose: Tester model driving the test port pins
// Assumes: Steps start just after a falling REF_CLK edge
// Notes:   TCK stands low between steps, 64 ns period
`timescale 1ns/1ps
module jtd_probe (
	output logic      TCK,
	output logic      TMS,
	output logic      TDI,
	input  wire logic TDO_OUT,
	input  wire logic TDO_OE
);
	initial begin
		TCK = 1'b0;
		TMS = 1'b1;
		TDI = 1'b0;
	end
	// TDO read just before the rise; released line reads unknown
	task automatic step(input logic m, input logic d, output logic o);
		TMS = m;
		TDI = d;
		#32 o = TDO_OE ? TDO_OUT : 1'bx;
		TCK = 1'b1;
		#32 TCK = 1'b0;
	endtask
endmodule

// ===== dv/jtd_tap_checker.sv
// Purpose: Concurrent checks on the test port outputs
// Assumes: Single REF_CLK domain
// Notes:   Design reacts a few REF_CLK after each TCK edge
`timescale 1ns/1ps
module jtd_tap_checker (
	input wire logic       REF_CLK,
	input wire logic       NRST,
	input wire logic       TCK,
	input wire logic       TDO_OUT,
	input wire logic       TDO_OE,
	input wire logic [7:0] IR_ACTIVE,
	input wire logic       MEM_CMD_STB,
	input wire logic       MEM_WR_STB,
	input wire logic       DBG_CTRL_STB,
	input wire logic       EXTEST_MODE,
	input wire logic       BIST_START,
	input wire logic       SCAN_TEST_MODE
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	a_oe_tck_low: assert property ($changed(TDO_OE) |-> !TCK)
		else $error("TDO enable moved with TCK high");
	a_tdo_tck_low: assert property ($changed(TDO_OUT) |-> !TCK)
		else $error("TDO moved with TCK high");
	a_ir_on_rise: assert property ($changed(IR_ACTIVE) |-> TCK)
		else $error("Instruction moved with TCK low");
	a_cmd_pulse: assert property (MEM_CMD_STB |-> IR_ACTIVE == 8'h10 ##1 !MEM_CMD_STB)
		else $error("Command strobe wrong");
	a_wr_pulse: assert property (MEM_WR_STB |-> IR_ACTIVE == 8'h12 ##1 !MEM_WR_STB)
		else $error("Write strobe wrong");
	a_dbg_strobe: assert property (DBG_CTRL_STB |-> IR_ACTIVE == 8'h14 && TCK)
		else $error("Debug strobe wrong");
	a_extest_lag: assert property (EXTEST_MODE == ($past(IR_ACTIVE) == 8'hF8))
		else $error("External test mode wrong");
	a_scan_level: assert property ($stable(IR_ACTIVE) |-> SCAN_TEST_MODE == (IR_ACTIVE == 8'h0F))
		else $error("Scan test mode wrong");
	a_bist_pulse: assert property ($rose(BIST_START) |-> IR_ACTIVE == 8'h07 ##1 !BIST_START)
		else $error("Self test start wrong");
endmodule
bind jtd_tap jtd_tap_checker jtd_tap_checker_inst (.REF_CLK, .NRST, .TCK, .TDO_OUT, .TDO_OE,
	.IR_ACTIVE, .MEM_CMD_STB, .MEM_WR_STB, .DBG_CTRL_STB, .EXTEST_MODE, .BIST_START,
	.SCAN_TEST_MODE);

// ===== dv/test_jtag_tap_debug_scan.sv
// Purpose: Self-checking bench for the test access port
// Assumes: Capture inputs held at zero unless a test sets them
// Notes:   Chain length found by leading zeros before shifted ones
`timescale 1ns/1ps
module test_jtag_tap_debug_scan;
	logic        REF_CLK = 1'b0, NRST = 1'b0;
	wire         TCK, TMS, TDI;
	logic        TDO_OUT, TDO_OE, MEM_CMD_STB, MEM_WR_STB, DBG_CTRL_STB;
	logic        EXTEST_MODE, BIST_START, SCAN_TEST_MODE;
	logic [36:0] MEM_CMD_CAP = 37'h0, PC_CTX_VALUE = 37'h0, MEM_CMD_OUT;
	logic [31:0] MEM_RD_VALUE = 32'h0, MEM_WR_CAP = 32'h0, MEM_WR_OUT;
	logic [14:0] DBG_CTRL_CAP = 15'h0, DBG_CTRL_OUT;
	logic [15:0] BIST_RESULT = 16'h0;
	logic [7:0]  PIN_IN = 8'h0, BSC_OUT, IR_ACTIVE;
	logic [47:0] so;
	int          n_mismatch = 0, n_compared = 0;
	jtd_tap jtd_tap_inst (.*);
	jtd_probe jtd_probe_inst (.TCK(TCK), .TMS(TMS), .TDI(TDI), .TDO_OUT(TDO_OUT), .TDO_OE(TDO_OE));
	always #2.5 REF_CLK = ~REF_CLK;
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic go(input logic m);
		logic o;
		jtd_probe_inst.step(m, 1'b0, o);
	endtask
	task automatic shift(input int n, input logic [47:0] din);
		so = 48'h0;
		for (int i = 0; i < n; i++)
			jtd_probe_inst.step(i == n - 1, din[i], so[i]);
		go(1'b1);
		go(1'b0);
	endtask
	task automatic dr(input int n, input logic [47:0] din);
		for (int i = 0; i < 3; i++)
			go(i == 0);
		shift(n, din);
	endtask
	task automatic ir(input logic [7:0] c);
		for (int i = 0; i < 4; i++)
			go(i < 2);
		shift(8, {40'h0, c});
		chk(so[7:0], 8'h01);
		chk(IR_ACTIVE, c);
	endtask
	task automatic t_id;
		go(1'b0);
		chk(IR_ACTIVE, 8'hFE);
		chk(TDO_OE, 1'b0);
		dr(32, 48'h0);
		chk(so[31:0], 32'h00000001);
		$display("t_id done");
	endtask
	task automatic t_codes;
		logic [7:0] c [11] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'hF8, 8'hFA, 8'hFF, 8'h07,
			8'h0F, 8'h55};
		int len [11] = '{37, 32, 32, 37, 15, 8, 8, 1, 16, 1, 1};
		int k;
		for (int j = 0; j < 11; j++) begin
			ir(c[j]);
			chk(EXTEST_MODE, c[j] == 8'hF8);
			chk(SCAN_TEST_MODE, c[j] == 8'h0F);
			dr(48, 48'hFFFFFFFFFFFF);
			k = 0;
			while (k < 47 && so[k] !== 1'b1)
				k++;
			chk(k, len[j]);
			if (c[j] == 8'h10)
				chk(MEM_CMD_OUT, 37'h1FFFFFFFFF);
			if (c[j] == 8'h12)
				chk(MEM_WR_OUT, 32'hFFFFFFFF);
		end
		$display("t_codes done");
	endtask
	task automatic t_upd;
		ir(8'h14);
		dr(15, 48'h5A3C);
		chk(DBG_CTRL_OUT, 15'h5A3C);
		@(negedge REF_CLK) PIN_IN = 8'hA5;
		ir(8'hFA);
		dr(8, 48'h3C);
		chk(so[7:0], 8'hA5);
		chk(BSC_OUT, 8'h3C);
		$display("t_upd done");
	endtask
	task automatic t_tlr;
		ir(8'hFF);
		repeat (3) go(1'b1);
		chk(IR_ACTIVE, 8'hFE);
		go(1'b0);
		ir(8'hFF);
		go(1'b1);
		repeat (2) go(1'b0);
		repeat (5) go(1'b1);
		chk(IR_ACTIVE, 8'hFE);
		go(1'b0);
		$display("t_tlr done");
	endtask
	task automatic results;
		$display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(negedge REF_CLK);
		NRST = 1'b1;
		repeat (4) @(negedge REF_CLK);
		t_id();
		t_codes();
		t_upd();
		t_tlr();
		results();
	end
	initial begin
		#400000;
		n_mismatch++;
		results();
	end
endmodule
